// file: rtl/ipx_pkg.sv
// shared constants and types of the two-wire port expander link
package ipx_pkg;

    // ------------------------------------------------------------
    // device address and port layout
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_FIXED = 3'h6;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam int IO_LO = 2;
    localparam int IO_W = 4;

    // ------------------------------------------------------------
    // controller registers (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_LEN = 8'h08;
    localparam logic [7:0] REG_TXDATA = 8'h0c;
    localparam logic [7:0] REG_RXDATA = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam int CTRL_GO = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_NACK = 1;
    localparam int STAT_DONE = 2;

    // ------------------------------------------------------------
    // serial clock timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int SCL_QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
                                     / (4 * CLK_PERIOD_NS);
    localparam logic [9:0] QUARTER_LAST = 10'(SCL_QUARTER_CYC - 1);

    typedef enum logic [2:0] {
        DEV_IDLE = 3'h0,
        DEV_ADDR = 3'h1,
        DEV_ADDR_ACK = 3'h2,
        DEV_WR_DATA = 3'h3,
        DEV_WR_ACK = 3'h4,
        DEV_RD_DATA = 3'h5,
        DEV_RD_ACK = 3'h6,
        DEV_IGNORE = 3'h7
    } ipx_dev_state_t;

    typedef enum logic [1:0] {
        MST_IDLE = 2'h0,
        MST_START = 2'h1,
        MST_BIT = 2'h2,
        MST_STOP = 2'h3
    } ipx_mst_state_t;

endpackage

// file: rtl/ipx_if.sv
// two-wire bus between controller and expander, wired-and resolution
interface ipx_if;
    logic mst_scl_o;
    logic mst_scl_oe_n;
    logic mst_sda_o;
    logic mst_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;

    // released lines float high through the pull-ups
    assign scl = mst_scl_oe_n | mst_scl_o;
    assign sda = (mst_sda_oe_n | mst_sda_o) & (dev_sda_oe_n | dev_sda_o);

    modport mst (input scl, input sda, output mst_scl_o, output mst_scl_oe_n,
                 output mst_sda_o, output mst_sda_oe_n);
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

// file: rtl/ipx_dev.sv
// expander end: two-wire slave, port latches, transition flags, alert
module ipx_dev
    import ipx_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    ipx_if.dev bus,
    input wire logic [1:0] addr_select_hi_pin_i,
    input wire logic [1:0] addr_select_lo_pin_i,
    input wire logic [7:0] port_i,
    output logic [7:0] port_o,
    output logic [IO_W-1:0] io_oe_n_o,
    output logic alert_n_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic [7:0] port_s1, port_s2;
    logic [3:0] sel_s1, sel_s2;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            scl_s1 <= 1'h1;
            scl_s2 <= 1'h1;
            scl_s3 <= 1'h1;
            sda_s1 <= 1'h1;
            sda_s2 <= 1'h1;
            sda_s3 <= 1'h1;
            // pins idle high, so start from that to avoid false flags
            port_s1 <= PORT_RESET;
            port_s2 <= PORT_RESET;
            sel_s1 <= 4'h0;
            sel_s2 <= 4'h0;
        end else begin
            scl_s1 <= bus.scl;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
            port_s1 <= port_i;
            port_s2 <= port_s1;
            sel_s1 <= {addr_select_hi_pin_i, addr_select_lo_pin_i};
            sel_s2 <= sel_s1;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
    assign stop_det = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
    assign scl_rise = scl_s2 && !scl_s3;
    assign scl_fall = !scl_s2 && scl_s3;

    // ------------------------------------------------------------
    // protocol state
    // ------------------------------------------------------------
    ipx_dev_state_t state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg;
    logic rw, next_rw;
    logic sda_oe_n, next_sda_oe_n;
    logic send_flags, next_send_flags;
    logic ack_taken, next_ack_taken;
    logic hold, next_hold;
    logic [IO_W-1:0] snapshot, next_snapshot;
    logic [IO_W-1:0] flags, next_flags;
    logic [IO_W-1:0] mask, next_mask;
    logic [7:0] port_out, next_port_out;
    logic alert_n, next_alert_n;

    logic [IO_W-1:0] io_live;
    assign io_live = port_s2[IO_LO +: IO_W];

    always_comb begin
        logic flags_clr;
        logic sample;
        flags_clr = 1'b0;
        sample = 1'b0;
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_rw = rw;
        next_sda_oe_n = sda_oe_n;
        next_send_flags = send_flags;
        next_ack_taken = ack_taken;
        next_hold = hold;
        next_snapshot = snapshot;
        next_mask = mask;
        next_port_out = port_out;
        if (start_det) begin
            next_state = DEV_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe_n = 1'b1;
        end else if (stop_det) begin
            next_state = DEV_IDLE;
            next_sda_oe_n = 1'b1;
            next_hold = 1'b0;
        end else begin
            case (state)
                DEV_ADDR, DEV_WR_DATA: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_s2};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                        if (state == DEV_WR_DATA) begin
                            next_port_out = shreg;
                            next_mask = shreg[IO_LO +: IO_W];
                            next_state = DEV_WR_ACK;
                            next_sda_oe_n = 1'b0;
                        end else if (shreg[7:1] == {ADDR_FIXED, sel_s2}) begin
                            next_rw = shreg[0];
                            next_sda_oe_n = 1'b0;
                            next_state = DEV_ADDR_ACK;
                            next_hold = 1'b1;
                            flags_clr = 1'b1;
                            sample = 1'b1;
                            next_send_flags = 1'b0;
                        end else begin
                            next_state = DEV_IGNORE;
                        end
                    end
                end
                DEV_ADDR_ACK, DEV_WR_ACK: begin
                    if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        if (state == DEV_ADDR_ACK && rw) begin
                            next_state = DEV_RD_DATA;
                            next_sda_oe_n = shreg[7];
                        end else begin
                            next_state = DEV_WR_DATA;
                            next_sda_oe_n = 1'b1;
                        end
                    end
                end
                DEV_RD_DATA: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == BYTE_BITS) begin
                            next_sda_oe_n = 1'b1;
                            next_state = DEV_RD_ACK;
                            next_ack_taken = 1'b0;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_sda_oe_n = shreg[6];
                        end
                    end
                end
                DEV_RD_ACK: begin
                    if (scl_rise && sda_s2) begin
                        next_state = DEV_IGNORE;
                    end else if (scl_rise) begin
                        next_ack_taken = 1'b1;
                        next_send_flags = !send_flags;
                        if (send_flags) begin
                            sample = 1'b1;
                            flags_clr = 1'b1;
                        end else begin
                            next_shreg = 8'({flags, 2'b00});
                        end
                    end else if (scl_fall && ack_taken) begin
                        next_bit_cnt = 4'h0;
                        next_state = DEV_RD_DATA;
                        next_sda_oe_n = shreg[7];
                    end
                end
                default: begin
                    next_sda_oe_n = 1'b1;
                end
            endcase
        end
        if (sample) begin
            next_shreg = port_s2;
            next_snapshot = io_live;
        end
        // differences from the new snapshot set flags
        next_flags = (flags_clr ? FLAGS_RESET : flags) | (next_snapshot ^ io_live);
        // suppressed from address ack to stop
        next_alert_n = !(|(next_flags & next_mask) && !next_hold);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state <= DEV_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rw <= 1'b0;
            sda_oe_n <= 1'b1;
            send_flags <= 1'b0;
            ack_taken <= 1'b0;
            hold <= 1'b0;
            snapshot <= PORT_RESET[IO_LO +: IO_W];
            flags <= FLAGS_RESET;
            mask <= MASK_RESET;
            port_out <= PORT_RESET;
            alert_n <= 1'b1;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            rw <= next_rw;
            sda_oe_n <= next_sda_oe_n;
            send_flags <= next_send_flags;
            ack_taken <= next_ack_taken;
            hold <= next_hold;
            snapshot <= next_snapshot;
            flags <= next_flags;
            mask <= next_mask;
            port_out <= next_port_out;
            alert_n <= next_alert_n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // pin value fixed low, enable carries data
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe_n = sda_oe_n;
    assign port_o = port_out;
    // io ports are open-drain: a one releases the pin so it can be read
    assign io_oe_n_o = port_out[IO_LO +: IO_W];
    assign alert_n_o = alert_n;

endmodule

// file: rtl/ipx_mst.sv
// controller end: register-driven two-wire master
module ipx_mst
    import ipx_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    ipx_if.mst bus,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);

    function automatic logic [7:0] get_byte(logic [31:0] w, logic [1:0] i);
        get_byte = w[8 * i +: 8];
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic sda_s1, sda_s2;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            sda_s1 <= 1'h1;
            sda_s2 <= 1'h1;
        end else begin
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
        end
    end

    // ------------------------------------------------------------
    // registers and sequencer
    // ------------------------------------------------------------
    ipx_mst_state_t state, next_state;
    logic [7:0] addr_rw, next_addr_rw;
    logic [1:0] len, next_len;
    logic [31:0] txdata, next_txdata;
    logic [31:0] rxdata, next_rxdata;
    logic [7:0] rxsh, next_rxsh;
    logic [31:0] rdata, next_rdata;
    logic nack, next_nack;
    logic done, next_done;
    logic [9:0] div, next_div;
    logic [1:0] q, next_q;
    logic [3:0] bitn, next_bitn;
    logic [2:0] idx, next_idx;
    logic scl_lvl, next_scl_lvl;
    logic sda_rel, next_sda_rel;

    always_comb begin
        logic tick, drives, last;
        logic [1:0] lane;
        logic [7:0] cur;
        tick = (state != MST_IDLE) && (div == QUARTER_LAST);
        lane = 2'(idx - 3'h1);
        drives = (idx == 3'h0) || !addr_rw[0];
        last = (idx != 3'h0) && (lane == len);
        cur = (idx == 3'h0) ? addr_rw : get_byte(txdata, lane);
        next_state = state;
        next_addr_rw = addr_rw;
        next_len = len;
        next_txdata = txdata;
        next_rxdata = rxdata;
        next_rxsh = rxsh;
        next_nack = nack;
        next_done = done;
        next_div = (state == MST_IDLE || tick) ? 10'h000 : div + 10'h001;
        next_q = tick ? q + 2'h1 : q;
        next_bitn = bitn;
        next_idx = idx;
        next_scl_lvl = scl_lvl;
        next_sda_rel = sda_rel;
        next_rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_ADDR: next_rdata = 32'(addr_rw);
                REG_LEN: next_rdata = 32'(len);
                REG_TXDATA: next_rdata = txdata;
                REG_RXDATA: next_rdata = rxdata;
                REG_STATUS: next_rdata = 32'({done, nack, state != MST_IDLE});
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        // configuration is frozen while a transfer runs
        if (reg_wr_i && state == MST_IDLE) begin
            case (reg_addr_i)
                REG_ADDR: next_addr_rw = reg_wdata_i[7:0];
                REG_LEN: next_len = reg_wdata_i[1:0];
                REG_TXDATA: next_txdata = reg_wdata_i;
                REG_CTRL: begin
                    if (reg_wdata_i[CTRL_GO]) begin
                        next_state = MST_START;
                        next_q = 2'h0;
                        next_nack = 1'b0;
                        next_done = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (tick) begin
            case (state)
                MST_START: begin
                    if (q == 2'h2) begin
                        next_sda_rel = 1'b0;
                    end else if (q == 2'h3) begin
                        next_scl_lvl = 1'b0;
                        next_state = MST_BIT;
                        next_bitn = 4'h0;
                        next_idx = 3'h0;
                    end
                end
                MST_BIT: begin
                    if (q == 2'h0) begin
                        if (bitn < BYTE_BITS) begin
                            next_sda_rel = drives ? cur[3'(4'h7 - bitn)] : 1'b1;
                        end else begin
                            // ack all but last read byte
                            next_sda_rel = drives || last;
                        end
                    end else if (q == 2'h1) begin
                        next_scl_lvl = 1'b1;
                    end else if (q == 2'h3) begin
                        next_scl_lvl = 1'b0;
                        next_bitn = bitn + 4'h1;
                        if (bitn < BYTE_BITS) begin
                            next_rxsh = {rxsh[6:0], sda_s2};
                        end else begin
                            if (!drives) begin
                                next_rxdata[8 * lane +: 8] = rxsh;
                            end
                            if (drives && sda_s2) begin
                                next_nack = 1'b1;
                                next_state = MST_STOP;
                            end else if (last) begin
                                next_state = MST_STOP;
                            end else begin
                                next_idx = idx + 3'h1;
                                next_bitn = 4'h0;
                            end
                        end
                    end
                end
                MST_STOP: begin
                    if (q == 2'h0) begin
                        next_sda_rel = 1'b0;
                    end else if (q == 2'h1) begin
                        next_scl_lvl = 1'b1;
                    end else if (q == 2'h2) begin
                        next_sda_rel = 1'b1;
                    end else begin
                        next_state = MST_IDLE;
                        next_done = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state <= MST_IDLE;
            addr_rw <= 8'h00;
            len <= 2'h0;
            txdata <= 32'h0000_0000;
            rxdata <= 32'h0000_0000;
            rxsh <= 8'h00;
            rdata <= 32'h0000_0000;
            nack <= 1'b0;
            done <= 1'b0;
            div <= 10'h000;
            q <= 2'h0;
            bitn <= 4'h0;
            idx <= 3'h0;
            scl_lvl <= 1'b1;
            sda_rel <= 1'b1;
        end else begin
            state <= next_state;
            addr_rw <= next_addr_rw;
            len <= next_len;
            txdata <= next_txdata;
            rxdata <= next_rxdata;
            rxsh <= next_rxsh;
            rdata <= next_rdata;
            nack <= next_nack;
            done <= next_done;
            div <= next_div;
            q <= next_q;
            bitn <= next_bitn;
            idx <= next_idx;
            scl_lvl <= next_scl_lvl;
            sda_rel <= next_sda_rel;
        end
    end

    // open-drain on both lines: enable low pulls the line low
    assign bus.mst_scl_o = 1'b0;
    assign bus.mst_scl_oe_n = scl_lvl;
    assign bus.mst_sda_o = 1'b0;
    assign bus.mst_sda_oe_n = sda_rel;
    assign reg_rdata_o = rdata;

endmodule

// file: tb/ipx_chk.sv
// concurrent checks on the two-wire link between controller and expander
module ipx_chk (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic mst_scl_o,
    input wire logic mst_sda_o,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // ------------------------------------------------------------
    // frame tracking and assertions
    // ------------------------------------------------------------
    // set by start, cleared by stop
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            busy <= 1'b0;
        end else if (scl && $fell(sda)) begin
            busy <= 1'b1;
        end else if (scl && $rose(sda)) begin
            busy <= 1'b0;
        end
    end
    dev_low_only_a: assert property (dev_sda_o == 1'b0)
        else $error("device drives data line high");
    mst_open_drain_a: assert property (mst_scl_o == 1'b0 && mst_sda_o == 1'b0)
        else $error("master drives a line high");
    dev_hold_high_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
        else $error("device moved data while clock high");
    scl_high_min_a: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    scl_low_min_a: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    start_form_a: assert property (scl && $fell(sda) |-> ##[100:200] $fell(scl))
        else $error("start not followed by clock fall");
    stop_free_a: assert property (scl && $rose(sda) |=> (scl && sda) [*8])
        else $error("bus not free after stop");
    dev_in_frame_a: assert property (!busy |-> dev_sda_oe_n)
        else $error("device pulls data outside a frame");
    start_c: cover property (scl && $fell(sda));
    stop_c: cover property (scl && $rose(sda));
    dev_ack_c: cover property ($fell(dev_sda_oe_n));
endmodule

// file: tb/tb_top.sv
// self-checking bench: controller and expander joined over the link
module tb_top
    import ipx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] io_ext = 4'hf;
    logic [31:0] reg_rdata, st, rx;
    logic [7:0] port_o, port_i;
    logic [3:0] io_oe_n;
    logic alert_n;
    int fail_count = 0;
    int comparisons = 0;
    // io ports are wired-and of the expander pull-down and the outside driver
    assign port_i = {port_o[7:6], io_ext & io_oe_n, port_o[1:0]};
    ipx_if bus_if ();
    ipx_dev u_ipx_dev (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus(bus_if.dev),
        .addr_select_hi_pin_i(2'h1), .addr_select_lo_pin_i(2'h2), .port_i(port_i),
        .port_o(port_o), .io_oe_n_o(io_oe_n), .alert_n_o(alert_n));
    ipx_mst u_ipx_mst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus(bus_if.mst),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
    ipx_chk u_ipx_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .mst_scl_o(bus_if.mst_scl_o), .mst_sda_o(bus_if.mst_sda_o),
        .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe_n(bus_if.dev_sda_oe_n),
        .scl(bus_if.scl), .sda(bus_if.sda));
    // ------------------------------------------------------------
    // register bus and compare tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic go(input logic [7:0] a, input logic [1:0] n, input logic [31:0] tx);
        wr(REG_ADDR, {24'h0, a});
        wr(REG_LEN, {30'h0, n});
        wr(REG_TXDATA, tx);
        wr(REG_CTRL, 32'h1);
    endtask
    // bounded poll, then fetch what was read
    task automatic fin();
        int i;
        i = 0;
        st = 32'h1;
        while (st[STAT_BUSY] !== 1'b0 && i < 20000) begin
            rd(REG_STATUS, st);
            i++;
        end
        chk({31'h0, st[STAT_BUSY]}, 32'h0);
        rd(REG_RXDATA, rx);
    endtask
    task automatic close_out();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_write();
        go(8'hcc, 2'h1, 32'h0000a55a);
        fin();
        chk({31'h0, st[STAT_NACK]}, 32'h0);
        chk({24'h0, port_o}, 32'ha5);
        chk({28'h0, io_oe_n}, 32'h9);
        $display("test write done");
    endtask
    task automatic s_nack();
        go(8'hce, 2'h0, 32'h12);
        fin();
        chk({31'h0, st[STAT_NACK]}, 32'h1);
        chk({24'h0, port_o}, 32'ha5);
        $display("test nack done");
    endtask
    task automatic s_read1();
        @(posedge clk_sys_i);
        io_ext <= 4'h7;
        repeat (20) @(posedge clk_sys_i);
        chk({31'h0, alert_n}, 32'h0);
        go(8'hcd, 2'h0, 32'h0);
        repeat (8000) @(posedge clk_sys_i);
        io_ext <= 4'hf;
        repeat (100) @(posedge clk_sys_i);
        chk({31'h0, alert_n}, 32'h1);
        fin();
        repeat (20) @(posedge clk_sys_i);
        chk({31'h0, alert_n}, 32'h0);
        chk({24'h0, rx[7:0]}, 32'h85);
        $display("test read1 done");
    endtask
    // change lands inside the port byte, so the flag byte must show it
    task automatic s_read2();
        go(8'hcd, 2'h1, 32'h0);
        repeat (8000) @(posedge clk_sys_i);
        io_ext <= 4'h7;
        fin();
        chk({16'h0, rx[15:0]}, 32'h20a5);
        $display("test read2 done");
    endtask
    // no port change: flags stay clear and the third byte is a fresh sample
    task automatic s_long();
        go(8'hcd, 2'h2, 32'h0);
        fin();
        repeat (20) @(posedge clk_sys_i);
        chk({31'h0, alert_n}, 32'h1);
        chk({8'h0, rx[23:0]}, 32'h0085_0085);
        $display("test long done");
    endtask
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        fail_count++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        s_write();
        s_nack();
        s_read1();
        s_read2();
        s_long();
        close_out();
    end
endmodule
